// ---- cpu_core_model.sv ----
// Core model that issues wait and stop strobes
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model
  import low_power_wake_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Bench command, op 1 wait, op 2 stop
  input wire logic go,
  input wire logic [1:0] op,
  // Controller side
  input wire lp_status_t status,
  output logic wait_instr,
  output logic stop_instr
);
  // A halted core fetches nothing, so no strobe while its clock is gated
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      wait_instr <= 1'b0;
      stop_instr <= 1'b0;
    end
    else
    begin
      wait_instr <= go && op == 2'h1 && status.cpu_clk_en;
      stop_instr <= go && op == 2'h2 && status.cpu_clk_en;
    end
  end
endmodule
`default_nettype wire

// ---- low_power_wake_control.sv ----
// Wait/stop mode controller with wake vectors and stop recovery
`timescale 1ns/1ps
`default_nettype none
`include "low_power_wake_defines.svh"
module low_power_wake_control
  import low_power_wake_pkg::*;
(
  // Clock (crystal reference) and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // CPU instruction strobes
  input wire logic wait_instr,
  input wire logic stop_instr,
  // Configuration
  input wire logic stop_instr_enable,
  input wire logic osc_run_in_stop,
  input wire logic short_stop_recovery,
  input wire logic irq_int_mask,
  input wire logic kbd_int_mask,
  input wire logic lvm_enable,
  input wire logic lvm_reset_enable,
  // Reset sources
  input wire logic ext_reset_n,
  input wire logic watchdog_timeout,
  input wire logic lvm_trip,
  // Interrupt requests
  input wire logic irq_pin,
  input wire logic kbd_req,
  input wire logic break_req,
  input wire logic pll_req,
  input wire logic [2:0] first_timer_unit_req,
  input wire logic [1:0] second_timer_unit_req,
  input wire logic [1:0] spi_req,
  input wire logic [2:0] sci_req,
  input wire logic adc_req,
  input wire logic tbm_req,
  // Clock gates to CPU and peripherals
  output lp_status_t status,
  output logic watchdog_clk_en,
  output logic watchdog_prescaler_clr,
  output logic lvm_active,
  output logic sci_clk_en,
  output logic spi_clk_en,
  output logic spi_reset,
  output logic timer_clk_en,
  output logic tbm_clk_en,
  output logic tbm_cpu_access_en,
  // Wake result to CPU
  output logic illegal_opcode_reset,
  output logic wake_reset,
  output logic wake_valid,
  output logic [15:0] wake_vector
);
  lp_state_t state_r, state_nxt;
  logic irq_pin_d_r;
  logic irq_edge;
  logic reset_src;
  logic [`NUM_SRC-1:0] pend;
  logic pend_any;
  logic [15:0] sel_vec;
  logic rec_start, rec_busy, rec_done;
  logic stop_by_reset_r;
  logic [15:0] held_vec_r;
  logic held_reset_r;
  logic ilop_r;
  logic valid_r;
  logic rst_r;
  logic [15:0] vec_r;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      irq_pin_d_r <= 1'b1;
    else
      irq_pin_d_r <= irq_pin;
  end
  assign irq_edge = irq_pin_d_r & ~irq_pin;

  // Reset causes that end either mode
  assign reset_src = ~ext_reset_n | watchdog_timeout | (lvm_enable & lvm_reset_enable & lvm_trip);

  // Pending wakes, masked per mode; sampled on the reference clock
  always_comb
  begin
    pend = '0;
    pend[0] = irq_edge & ~irq_int_mask;
    pend[1] = break_req;
    pend[13] = kbd_req & ~kbd_int_mask;
    pend[15] = tbm_req & ((state_r != ST_STOP) | osc_run_in_stop);
    if (state_r != ST_STOP)
    begin
      pend[2] = pll_req;
      pend[5:3] = {first_timer_unit_req[0], first_timer_unit_req[1], first_timer_unit_req[2]};
      pend[7:6] = {second_timer_unit_req[0], second_timer_unit_req[1]};
      pend[9:8] = {spi_req[0], spi_req[1]};
      pend[12:10] = {sci_req[0], sci_req[1], sci_req[2]};
      pend[14] = adc_req;
    end
  end
  // first_timer_unit_req: [0]=ovf [1]=ch1 [2]=ch0; second_timer_unit_req: [0]=ovf [1]=ch0
  // spi_req: [0]=tx [1]=rx; sci_req: [0]=tx [1]=rx [2]=err

  wake_vector_select u_sel
  (
    .pend(pend),
    .any(pend_any),
    .vector(sel_vec)
  );

  // Leaving stop needs the recovery delay; wait exits immediately
  assign rec_start = (state_r == ST_STOP) && (reset_src || pend_any);

  recovery_counter u_rec
  (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .start(rec_start),
    .short_sel(short_stop_recovery),
    .busy(rec_busy),
    .done(rec_done)
  );

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RUN:
      begin
        if (stop_instr && stop_instr_enable)
          state_nxt = ST_STOP;
        else if (wait_instr)
          state_nxt = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (reset_src || pend_any)
          state_nxt = ST_RUN;
      end
      ST_STOP:
      begin
        if (rec_start)
          state_nxt = ST_RECOVER;
      end
      ST_RECOVER:
      begin
        if (rec_done)
          state_nxt = ST_RUN;
      end
      default: state_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      state_r <= ST_RUN;
    else
      state_r <= state_nxt;
  end

  // Stop exit cause is latched so the vector survives the recovery delay
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      held_vec_r <= `VEC_RESET;
      held_reset_r <= 1'b0;
      stop_by_reset_r <= 1'b0;
    end
    else if (rec_start)
    begin
      held_vec_r <= reset_src ? `VEC_RESET : sel_vec;
      held_reset_r <= reset_src;
      stop_by_reset_r <= reset_src;
    end
    else if (state_r == ST_RUN)
      stop_by_reset_r <= 1'b0;
  end

  // One-cycle wake result to the CPU
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      valid_r <= 1'b0;
      rst_r <= 1'b0;
      vec_r <= `VEC_RESET;
    end
    else if (state_r == ST_WAIT && (reset_src || pend_any))
    begin
      valid_r <= 1'b1;
      rst_r <= reset_src;
      vec_r <= reset_src ? `VEC_RESET : sel_vec;
    end
    else if (state_r == ST_RECOVER && rec_done)
    begin
      valid_r <= 1'b1;
      rst_r <= held_reset_r;
      vec_r <= held_vec_r;
    end
    else
    begin
      valid_r <= 1'b0;
      rst_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      ilop_r <= 1'b0;
    else
      ilop_r <= (state_r == ST_RUN) && stop_instr && !stop_instr_enable;
  end

  logic in_stop;
  logic in_low;
  assign in_stop = (state_r == ST_STOP) || (state_r == ST_RECOVER) || rec_busy;
  assign in_low = in_stop || (state_r == ST_WAIT);

  // Only the CPU clock stops in wait; in stop the bus clock runs only with the oscillator kept running
  assign status.wait_mode = (state_r == ST_WAIT);
  assign status.stop_mode = in_stop;
  assign status.cpu_clk_en = ~in_low;
  assign status.bus_clk_en = ~in_stop | osc_run_in_stop;
  assign watchdog_clk_en = ~in_stop;
  assign watchdog_prescaler_clr = in_stop;
  assign lvm_active = lvm_enable;
  assign sci_clk_en = ~in_stop;
  assign spi_clk_en = ~in_stop;
  assign spi_reset = stop_by_reset_r | (rec_start & reset_src);
  assign timer_clk_en = ~in_stop;
  assign tbm_clk_en = ~in_stop | osc_run_in_stop;
  assign tbm_cpu_access_en = ~in_low;
  assign illegal_opcode_reset = ilop_r;
  assign wake_reset = rst_r;
  assign wake_valid = valid_r;
  assign wake_vector = vec_r;
endmodule
`default_nettype wire

// ---- low_power_wake_control_asserts.sv ----
// Port-level checks for the low-power wake controller
`timescale 1ns/1ps
`default_nettype none
`include "low_power_wake_defines.svh"
module low_power_wake_control_asserts
  import low_power_wake_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Watched inputs
  input wire logic stop_instr,
  input wire logic stop_instr_enable,
  input wire logic osc_run_in_stop,
  input wire logic short_stop_recovery,
  input wire logic irq_int_mask,
  input wire logic lvm_enable,
  input wire logic ext_reset_n,
  input wire logic watchdog_timeout,
  input wire logic irq_pin,
  // Watched outputs
  input wire lp_status_t status,
  input wire logic watchdog_clk_en,
  input wire logic lvm_active,
  input wire logic sci_clk_en,
  input wire logic spi_clk_en,
  input wire logic timer_clk_en,
  input wire logic tbm_clk_en,
  input wire logic tbm_cpu_access_en,
  input wire logic illegal_opcode_reset,
  input wire logic wake_valid,
  input wire logic wake_reset,
  input wire logic [15:0] wake_vector
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  // Recovery keeps the core halted and silent before the answer
  sequence s_held;
    (status.stop_mode && !wake_valid && !status.cpu_clk_en) [*8];
  endsequence
  // The answer comes with the fall of stop, after at least the short delay
  sequence s_exit;
    wake_valid && !status.stop_mode && status.cpu_clk_en && $past(status.stop_mode, 32);
  endsequence
  chk_stop_hold: assert property (
    $rose(status.stop_mode) |-> s_held)
    else $error("stop left too early");
  chk_wait_clocks: assert property (
    status.wait_mode |-> !status.cpu_clk_en && status.bus_clk_en && watchdog_clk_en && sci_clk_en
      && spi_clk_en && timer_clk_en && tbm_clk_en && !tbm_cpu_access_en)
    else $error("wait clock gates wrong");
  chk_stop_clocks: assert property (
    status.stop_mode |-> !status.cpu_clk_en && status.bus_clk_en == osc_run_in_stop && !watchdog_clk_en
      && !sci_clk_en && !spi_clk_en && !timer_clk_en && tbm_clk_en == osc_run_in_stop && !tbm_cpu_access_en)
    else $error("stop clock gates wrong");
  chk_lvm_kept_on: assert property (
    (status.wait_mode || status.stop_mode) && lvm_enable |-> lvm_active)
    else $error("voltage monitor off in low power");
  chk_stop_entry: assert property (
    status.cpu_clk_en && stop_instr && stop_instr_enable |=> status.stop_mode && !illegal_opcode_reset)
    else $error("enabled stop not entered");
  chk_illegal_stop: assert property (
    status.cpu_clk_en && stop_instr && !stop_instr_enable |=> illegal_opcode_reset && !status.stop_mode)
    else $error("disabled stop not refused");
  chk_wait_reset: assert property (
    status.wait_mode && (!ext_reset_n || watchdog_timeout)
      |-> ##[1:2] (wake_valid && wake_reset && wake_vector == `VEC_RESET))
    else $error("reset did not end wait");
  chk_wait_irq: assert property (
    status.wait_mode && !irq_int_mask && $fell(irq_pin) |-> ##[1:3] (wake_valid && wake_vector == `VEC_IRQ))
    else $error("irq edge did not end wait");
  chk_short_recov: assert property (
    $fell(status.stop_mode) && short_stop_recovery |-> s_exit)
    else $error("short recovery length wrong");
endmodule
bind low_power_wake_control low_power_wake_control_asserts u_chk (.clk_sys, .resetn, .stop_instr,
  .stop_instr_enable, .osc_run_in_stop, .short_stop_recovery, .irq_int_mask, .lvm_enable, .ext_reset_n,
  .watchdog_timeout, .irq_pin, .status, .watchdog_clk_en, .lvm_active, .sci_clk_en, .spi_clk_en,
  .timer_clk_en, .tbm_clk_en, .tbm_cpu_access_en, .illegal_opcode_reset, .wake_valid, .wake_reset,
  .wake_vector);
`default_nettype wire

// ---- low_power_wake_control_tb.sv ----
// Bench for the low-power wake controller
`timescale 1ns/1ps
`default_nettype none
module low_power_wake_control_tb;
  import low_power_wake_pkg::*;
  logic clk_sys = 1'b0, resetn = 1'b0, go = 1'b0, sen = 1'b1, osc = 1'b0, ssr = 1'b0, im = 1'b0;
  logic km = 1'b0, lve = 1'b1, lvr = 1'b1, rst_n = 1'b1, wdt = 1'b0, lvt = 1'b0, irq = 1'b1;
  logic [1:0] op = 2'h0;
  logic [14:0] src = 15'h0;
  logic wi, si, ilop, wrst, wv, spr, sp, il;
  lp_status_t st;
  logic [15:0] vec;
  int bad_count = 0, tests_run = 0, n, k;
  logic [15:0] vt [15] = '{16'hfffc, 16'hfff8, 16'hfff2, 16'hfff4, 16'hfff6, 16'hffec, 16'hfff0,
    16'hffe8, 16'hffea, 16'hffe2, 16'hffe4, 16'hffe6, 16'hffde, 16'hffdc, 16'hffde};
  logic [15:0] xv [4] = '{16'hffdc, 16'hffde, 16'hfffc, 16'hfffe};
  cpu_core_model u_cpu (.clk_sys(clk_sys), .resetn(resetn), .go(go), .op(op), .status(st),
    .wait_instr(wi), .stop_instr(si));
  low_power_wake_control u_dut (.clk_sys(clk_sys), .resetn(resetn), .wait_instr(wi), .stop_instr(si),
    .stop_instr_enable(sen), .osc_run_in_stop(osc), .short_stop_recovery(ssr), .irq_int_mask(im),
    .kbd_int_mask(km), .lvm_enable(lve), .lvm_reset_enable(lvr), .ext_reset_n(rst_n),
    .watchdog_timeout(wdt), .lvm_trip(lvt), .irq_pin(irq), .kbd_req(src[14]), .break_req(src[0]),
    .pll_req(src[1]), .first_timer_unit_req(src[4:2]), .second_timer_unit_req(src[6:5]), .spi_req(src[8:7]),
    .sci_req(src[11:9]), .adc_req(src[12]), .tbm_req(src[13]), .status(st), .watchdog_clk_en(),
    .watchdog_prescaler_clr(), .lvm_active(), .sci_clk_en(), .spi_clk_en(), .spi_reset(spr),
    .timer_clk_en(), .tbm_clk_en(), .tbm_cpu_access_en(), .illegal_opcode_reset(ilop),
    .wake_reset(wrst), .wake_valid(wv), .wake_vector(vec));
  initial
  begin
    forever #4 clk_sys = ~clk_sys;
  end
  task close_out;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Samples on falling edges, where the pulses have settled
  task grab(input int lim);
    n = 0;
    sp = 1'b0;
    il = 1'b0;
    do
    begin
      @(negedge clk_sys);
      n++;
      sp = sp | spr;
      il = il | ilop;
    end
    while (n < lim && wv !== 1'b1);
  endtask
  task enter(input logic [1:0] o);
    @(posedge clk_sys);
    op <= o;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    grab(4);
    @(posedge clk_sys);
  endtask
  task clear;
    @(posedge clk_sys);
    src <= 15'h0;
    irq <= 1'b1;
    rst_n <= 1'b1;
    wdt <= 1'b0;
    lvt <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  initial
  begin
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    @(negedge clk_sys);
    chk("run_status", {12'h0, st}, 16'h3);
    for (k = 0; k < 15; k++)
    begin
      enter(2'h1);
      chk("wait_status", {12'h0, st}, 16'h9);
      src[k] <= 1'b1;
      grab(8);
      chk("wait_vector", vec, vt[k]);
      chk("wait_latency", {15'h0, n < 6}, 16'h1);
      clear;
    end
    enter(2'h1);
    irq <= 1'b0;
    grab(8);
    chk("wait_irq", vec, 16'hfffa);
    clear;
    for (k = 0; k < 3; k++)
    begin
      enter(2'h1);
      im <= 1'b1;
      irq <= 1'b0;
      grab(20);
      chk("masked_irq", {15'h0, wv}, 16'h0);
      @(posedge clk_sys);
      rst_n <= k != 0;
      wdt <= k == 1;
      lvt <= k == 2;
      grab(8);
      chk("reset_vector", vec, 16'hfffe);
      chk("reset_flag", {15'h0, wrst}, 16'h1);
      clear;
      im <= 1'b0;
    end
    sen <= 1'b0;
    enter(2'h2);
    chk("illegal_pulse", {15'h0, il}, 16'h1);
    chk("stop_refused", {12'h0, st}, 16'h3);
    sen <= 1'b1;
    enter(2'h2);
    chk("stop_status", {12'h0, st}, 16'h4);
    src[13:12] <= 2'h3;
    grab(40);
    chk("stop_ignores", {12'h0, st}, 16'h4);
    @(posedge clk_sys);
    src <= 15'h0;
    irq <= 1'b0;
    grab(4300);
    chk("long_vector", vec, 16'hfffa);
    chk("long_recovery", {15'h0, n > 4090 && n < 4110}, 16'h1);
    clear;
    // Short recovery only because this bench models no crystal
    ssr <= 1'b1;
    osc <= 1'b1;
    for (k = 0; k < 4; k++)
    begin
      enter(2'h2);
      chk("stop_osc", {12'h0, st}, 16'h5);
      @(posedge clk_sys);
      rst_n <= k != 3;
      src[13] <= k == 0;
      src[14] <= k == 1;
      src[0] <= k == 2;
      grab(60);
      chk("stop_vector", vec, xv[k]);
      chk("short_recovery", {15'h0, n > 28 && n < 48}, 16'h1);
      chk("spi_reset", {15'h0, sp}, {15'h0, k == 3});
      clear;
    end
    close_out;
  end
  // The sequence needs about 4650 cycles, so 10000 leaves margin
  initial
  begin
    #80000;
    bad_count++;
    close_out;
  end
endmodule
`default_nettype wire

// ---- low_power_wake_defines.svh ----
// Constants for the low-power wake controller
`ifndef LOW_POWER_WAKE_DEFINES_SVH
`define LOW_POWER_WAKE_DEFINES_SVH
`define VEC_RESET 16'hfffe
`define VEC_IRQ 16'hfffa
`define VEC_BREAK 16'hfffc
`define VEC_PLL 16'hfff8
`define VEC_FIRST_TIMER_UNIT_OVF 16'hfff2
`define VEC_FIRST_TIMER_UNIT_CH1 16'hfff4
`define VEC_FIRST_TIMER_UNIT_CH0 16'hfff6
`define VEC_SECOND_TIMER_UNIT_OVF 16'hffec
`define VEC_SECOND_TIMER_UNIT_CH0 16'hfff0
`define VEC_SPI_TX 16'hffe8
`define VEC_SPI_RX 16'hffea
`define VEC_SCI_TX 16'hffe2
`define VEC_SCI_RX 16'hffe4
`define VEC_SCI_ERR 16'hffe6
`define VEC_ADC 16'hffde
`define VEC_KBD 16'hffde
`define VEC_TBM 16'hffdc
`define NUM_SRC 17
`define REC_LONG_CYCLES 12'hfff
`define REC_SHORT_CYCLES 12'h01f
`define REC_CNT_W 12
`endif

// ---- low_power_wake_pkg.sv ----
// Types for the low-power wake controller
package low_power_wake_pkg;
  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_STOP = 4'b0100,
    ST_RECOVER = 4'b1000
  } lp_state_t;
  typedef struct packed {
    logic wait_mode;
    logic stop_mode;
    logic cpu_clk_en;
    logic bus_clk_en;
  } lp_status_t;
endpackage

// ---- recovery_counter.sv ----
// Stop recovery down counter holding system clocks off
`timescale 1ns/1ps
`default_nettype none
`include "low_power_wake_defines.svh"
module recovery_counter
  import low_power_wake_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Control
  input wire logic start,
  input wire logic short_sel,
  // Status
  output logic busy,
  output logic done
);
  logic [`REC_CNT_W-1:0] cnt_r;
  logic busy_r;
  // 12-bit count, 4096 or 32 cycles after the load cycle
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_r <= '0;
      busy_r <= 1'b0;
    end
    else if (start)
    begin
      cnt_r <= short_sel ? `REC_SHORT_CYCLES : `REC_LONG_CYCLES;
      busy_r <= 1'b1;
    end
    else if (busy_r)
    begin
      if (cnt_r == '0)
        busy_r <= 1'b0;
      else
        cnt_r <= cnt_r - 1'b1;
    end
  end
  assign busy = busy_r | start;
  assign done = busy_r && (cnt_r == '0);
endmodule
`default_nettype wire

// ---- wake_vector_select.sv ----
// Priority encoder from pending wake sources to a vector address
`timescale 1ns/1ps
`default_nettype none
`include "low_power_wake_defines.svh"
module wake_vector_select
  import low_power_wake_pkg::*;
(
  // Sources, index 0 has highest priority
  input wire logic [`NUM_SRC-1:0] pend,
  // Result
  output logic any,
  output logic [15:0] vector
);
  localparam logic [15:0] VEC_TAB [`NUM_SRC] = '{`VEC_IRQ, `VEC_BREAK, `VEC_PLL, `VEC_FIRST_TIMER_UNIT_CH0,
    `VEC_FIRST_TIMER_UNIT_CH1, `VEC_FIRST_TIMER_UNIT_OVF, `VEC_SECOND_TIMER_UNIT_CH0, `VEC_SECOND_TIMER_UNIT_OVF, `VEC_SPI_RX, `VEC_SPI_TX,
    `VEC_SCI_ERR, `VEC_SCI_RX, `VEC_SCI_TX, `VEC_KBD, `VEC_ADC, `VEC_TBM, `VEC_RESET};
  always_comb
  begin
    any = |pend;
    vector = `VEC_RESET;
    for (int i = `NUM_SRC - 1; i >= 0; i--)
    begin
      if (pend[i])
        vector = VEC_TAB[i];
    end
  end
endmodule
`default_nettype wire
